/* rtl/eeprom_access_pkg.sv */
package eeprom_access_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_ACCESS = 12'h0bc;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h100;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h104;

	// Field positions inside the access register.
	localparam int B_START = 0;
	localparam int B_WRITE = 1;
	localparam int B_ERR = 2;
	localparam int B_AL_OK = 3;
	localparam int B_AL_STAT = 4;
	localparam int B_AL_DIS = 5;
	localparam int RATE_LSB = 6;
	localparam int WADDR_LSB = 9;
	localparam int DATA_LSB = 16;

	localparam logic [1:0] RATE_RESET = 2'h1;
	localparam logic [1:0] RATE_TEST = 2'h3;
	localparam logic AL_DIS_RESET = 1'b1;
	localparam logic [6:0] WADDR_RESET = 7'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// Two-wire device select of the memory; the direction bit is appended below it as the low bit.
	localparam logic [6:0] DEV_SEL = 7'h50;

	// Interrupt status and mask layout.
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_AUTOLOAD = 2;

	// Serial rate: primary clock over the divider, mapped onto our own clock.
	localparam longint PRIMARY_HZ = 125000000;
	localparam longint RATE_DIV = 1024;
	localparam longint CLK_HZ = 50000000;
	// One bit takes four quarter phases; a longest time rounds down.
	localparam int QUARTER_CYCLES = int'((CLK_HZ * RATE_DIV) / (PRIMARY_HZ * 4));

	localparam int AUTOLOAD_WORDS = 4;

	typedef enum logic [1:0] {
		CMD_START,
		CMD_STOP,
		CMD_WRITE,
		CMD_READ
	} twi_cmd_t;
endpackage

/* rtl/eeprom_access_port.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_port #(
	parameter int QUARTER_CYCLES = eeprom_access_pkg::QUARTER_CYCLES,
	parameter int AUTOLOAD_WORDS = eeprom_access_pkg::AUTOLOAD_WORDS
) (
	input wire logic clk, // system clock, 50 MHz
	input wire logic nrst, // async reset, active low
	input wire logic [11:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	output logic irq, // level interrupt
	output logic scl_out, // clock line output level
	output logic scl_oe, // clock line pulled low
	input wire logic sda_in, // data line level
	output logic sda_out, // data line output level
	output logic sda_oe, // data line pulled low
	output logic cfg_load_valid, // one-cycle autoloaded word
	output logic [6:0] cfg_load_addr, // word address of loaded word
	output logic [15:0] cfg_load_data // loaded word
);
	if (AUTOLOAD_WORDS < 1 || AUTOLOAD_WORDS > 128) begin : bad_words
		$error("AUTOLOAD_WORDS must be 1 to 128");
	end

	typedef enum logic [3:0] {
		S_IDLE,
		S_START,
		S_DEV_W,
		S_WADDR,
		S_WR_HI,
		S_WR_LO,
		S_RSTART,
		S_DEV_R,
		S_RD_HI,
		S_RD_LO,
		S_STOP
	} seq_state_t;

	function automatic eeprom_access_pkg::twi_cmd_t cmd_of(input seq_state_t s);
		case (s)
			S_START, S_RSTART: cmd_of = eeprom_access_pkg::CMD_START;
			S_STOP: cmd_of = eeprom_access_pkg::CMD_STOP;
			S_RD_HI, S_RD_LO: cmd_of = eeprom_access_pkg::CMD_READ;
			default: cmd_of = eeprom_access_pkg::CMD_WRITE;
		endcase
	endfunction

	// Access register fields.
	logic start, next_start;
	logic op_write, next_op_write;
	logic ack_err, next_ack_err;
	logic al_ok, next_al_ok;
	logic al_stat, next_al_stat;
	logic al_dis, next_al_dis;
	logic [1:0] rate, next_rate;
	logic [6:0] word_addr, next_word_addr;
	logic [15:0] data, next_data;
	// Sequencer.
	seq_state_t state, next_state;
	logic issued, next_issued;
	logic cur_write, next_cur_write;
	logic cur_auto, next_cur_auto;
	logic fail, next_fail;
	logic al_armed, next_al_armed;
	logic [6:0] cur_addr, next_cur_addr;
	logic [7:0] hi_byte, next_hi_byte;
	// Interrupts and bus.
	logic [2:0] irq_status, next_irq_status;
	logic [2:0] irq_mask, next_irq_mask;
	logic [2:0] irq_set;
	logic [31:0] next_rdata;
	logic next_cfg_valid;
	logic [6:0] next_cfg_addr;
	logic [15:0] next_cfg_data;
	// Engine.
	logic tick, eng_busy, eng_done, eng_ack_missing, eng_valid;
	logic [7:0] eng_rx, eng_tx;
	logic sel_access, sel_status, sel_mask;

	serial_rate_divider #(
		.QUARTER(QUARTER_CYCLES)
	) serial_rate_divider_inst (
		.clk(clk),
		.nrst(nrst),
		.test_mode(rate == eeprom_access_pkg::RATE_TEST),
		.tick(tick)
	);

	twi_byte_engine twi_byte_engine_inst (
		.clk(clk),
		.nrst(nrst),
		.tick(tick),
		.cmd_valid(eng_valid),
		.cmd(cmd_of(state)),
		.tx_byte(eng_tx),
		.master_nack(state == S_RD_LO),
		.sda_in(sda_in),
		.busy(eng_busy),
		.done(eng_done),
		.ack_missing(eng_ack_missing),
		.rx_byte(eng_rx),
		.scl_oe(scl_oe),
		.sda_oe(sda_oe)
	);

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign irq = |(irq_status & irq_mask);
	assign eng_valid = (state != S_IDLE) && !issued && !eng_busy;

	always_comb begin
		case (state)
			S_DEV_W: eng_tx = {eeprom_access_pkg::DEV_SEL, 1'b0};
			S_DEV_R: eng_tx = {eeprom_access_pkg::DEV_SEL, 1'b1};
			S_WADDR: eng_tx = {1'b0, cur_addr};
			S_WR_HI: eng_tx = data[15:8];
			S_WR_LO: eng_tx = data[7:0];
			default: eng_tx = 8'h00;
		endcase
	end

	always_comb begin
		sel_access = 1'b0;
		sel_status = 1'b0;
		sel_mask = 1'b0;
		if (addr == eeprom_access_pkg::OFF_ACCESS) begin
			sel_access = 1'b1;
		end else if (addr == eeprom_access_pkg::OFF_IRQ_STATUS) begin
			sel_status = 1'b1;
		end else if (addr == eeprom_access_pkg::OFF_IRQ_MASK) begin
			sel_mask = 1'b1;
		end
	end

	always_comb begin
		next_start = start;
		next_op_write = op_write;
		next_ack_err = ack_err;
		next_al_ok = al_ok;
		next_al_stat = al_stat;
		next_al_dis = al_dis;
		next_rate = rate;
		next_word_addr = word_addr;
		next_data = data;
		next_state = state;
		next_issued = issued;
		next_cur_write = cur_write;
		next_cur_auto = cur_auto;
		next_fail = fail;
		next_al_armed = al_armed;
		next_cur_addr = cur_addr;
		next_hi_byte = hi_byte;
		next_irq_mask = irq_mask;
		next_cfg_valid = 1'b0;
		next_cfg_addr = cfg_load_addr;
		next_cfg_data = cfg_load_data;
		irq_set = 3'h0;
		next_rdata = 32'h0000_0000;

		// Register reads; the read clears the autoload status before any set below.
		if (rd) begin
			if (sel_access) begin
				next_rdata = {data, word_addr, 1'b0, rate, al_dis, al_stat, al_ok,
					ack_err, op_write, start};
				next_al_stat = 1'b0;
			end else if (sel_status) begin
				next_rdata = {29'h0, irq_status};
			end else if (sel_mask) begin
				next_rdata = {29'h0, irq_mask};
			end
		end

		// A running software access keeps its fields; writes to them are dropped.
		if (wr && sel_access && !start) begin
			next_start = wdata[eeprom_access_pkg::B_START];
			next_op_write = wdata[eeprom_access_pkg::B_WRITE];
			next_al_dis = wdata[eeprom_access_pkg::B_AL_DIS];
			next_rate = wdata[eeprom_access_pkg::RATE_LSB +: 2];
			next_word_addr = wdata[eeprom_access_pkg::WADDR_LSB +: 7];
			next_data = wdata[eeprom_access_pkg::DATA_LSB +: 16];
		end
		if (wr && sel_mask) begin
			next_irq_mask = wdata[2:0];
		end

		// Launch: autoload goes first so configuration lands before software access.
		if (state == S_IDLE) begin
			if (al_armed && !al_dis) begin
				next_al_armed = 1'b0;
				next_cur_auto = 1'b1;
				next_cur_write = 1'b0;
				next_cur_addr = 7'h00;
				next_fail = 1'b0;
				next_state = S_START;
			end else if (start) begin
				next_cur_auto = 1'b0;
				next_cur_write = op_write;
				next_cur_addr = word_addr;
				next_fail = 1'b0;
				next_ack_err = 1'b0;
				next_state = S_START;
			end
		end else if (eng_valid) begin
			next_issued = 1'b1;
		end else if (eng_done) begin
			next_issued = 1'b0;
			case (state)
				S_START: next_state = S_DEV_W;
				S_DEV_W: next_state = S_WADDR;
				S_WADDR: next_state = cur_write ? S_WR_HI : S_RSTART;
				S_WR_HI: next_state = S_WR_LO;
				S_WR_LO: next_state = S_STOP;
				S_RSTART: next_state = S_DEV_R;
				S_DEV_R: next_state = S_RD_HI;
				S_RD_HI: begin
					next_hi_byte = eng_rx;
					next_state = S_RD_LO;
				end
				S_RD_LO: begin
					if (cur_auto) begin
						next_cfg_valid = 1'b1;
						next_cfg_addr = cur_addr;
						next_cfg_data = {hi_byte, eng_rx};
					end else begin
						next_data = {hi_byte, eng_rx};
					end
					next_state = S_STOP;
				end
				S_STOP: begin
					next_state = S_IDLE;
					if (cur_auto) begin
						if (fail) begin
							next_al_ok = 1'b0;
							irq_set[eeprom_access_pkg::IRQ_AUTOLOAD] = 1'b1;
							irq_set[eeprom_access_pkg::IRQ_ERR] = 1'b1;
						end else if (cur_addr == 7'(AUTOLOAD_WORDS - 1)) begin
							next_al_ok = 1'b1;
							next_al_stat = 1'b1;
							irq_set[eeprom_access_pkg::IRQ_AUTOLOAD] = 1'b1;
						end else begin
							next_cur_addr = cur_addr + 7'h01;
							next_state = S_START;
						end
					end else begin
						next_start = 1'b0;
						next_ack_err = fail;
						irq_set[eeprom_access_pkg::IRQ_DONE] = 1'b1;
						irq_set[eeprom_access_pkg::IRQ_ERR] = fail;
					end
				end
				default: next_state = S_IDLE;
			endcase
			// A byte the memory did not acknowledge ends the access at once.
			if (eng_ack_missing && state != S_STOP) begin
				next_fail = 1'b1;
				next_state = S_STOP;
			end
		end

		// Write-one-to-clear; a set in the same cycle wins.
		next_irq_status = irq_status;
		if (wr && sel_status) begin
			next_irq_status = irq_status & ~wdata[2:0];
		end
		next_irq_status = next_irq_status | irq_set;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start <= 1'b0;
			op_write <= 1'b0;
			ack_err <= 1'b0;
			al_ok <= 1'b0;
			al_stat <= 1'b0;
			al_dis <= eeprom_access_pkg::AL_DIS_RESET;
			rate <= eeprom_access_pkg::RATE_RESET;
			word_addr <= eeprom_access_pkg::WADDR_RESET;
			data <= eeprom_access_pkg::DATA_RESET;
			state <= S_IDLE;
			issued <= 1'b0;
			cur_write <= 1'b0;
			cur_auto <= 1'b0;
			fail <= 1'b0;
			al_armed <= 1'b1;
			cur_addr <= 7'h00;
			hi_byte <= 8'h00;
			irq_status <= 3'h0;
			irq_mask <= 3'h0;
			rdata <= 32'h0000_0000;
			cfg_load_valid <= 1'b0;
			cfg_load_addr <= 7'h00;
			cfg_load_data <= 16'h0000;
		end else begin
			start <= next_start;
			op_write <= next_op_write;
			ack_err <= next_ack_err;
			al_ok <= next_al_ok;
			al_stat <= next_al_stat;
			al_dis <= next_al_dis;
			rate <= next_rate;
			word_addr <= next_word_addr;
			data <= next_data;
			state <= next_state;
			issued <= next_issued;
			cur_write <= next_cur_write;
			cur_auto <= next_cur_auto;
			fail <= next_fail;
			al_armed <= next_al_armed;
			cur_addr <= next_cur_addr;
			hi_byte <= next_hi_byte;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			rdata <= next_rdata;
			cfg_load_valid <= next_cfg_valid;
			cfg_load_addr <= next_cfg_addr;
			cfg_load_data <= next_cfg_data;
		end
	end
endmodule // eeprom_access_port
`default_nettype wire

/* rtl/serial_rate_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_rate_divider #(
	parameter int QUARTER = eeprom_access_pkg::QUARTER_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic test_mode, // tick every cycle
	output logic tick // one-cycle quarter-phase enable
);
	localparam int CW = $clog2(QUARTER + 1);

	if (QUARTER < 2) begin : bad_quarter
		$error("QUARTER must be at least 2");
	end

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [CW-1:0] limit;
	logic next_tick;

	always_comb begin
		limit = test_mode ? '0 : CW'(QUARTER - 1);
		next_tick = (count >= limit);
		next_count = next_tick ? '0 : count + CW'(1);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule // serial_rate_divider
`default_nettype wire

/* rtl/twi_byte_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module twi_byte_engine (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic tick, // quarter-phase enable
	input wire logic cmd_valid, // take a command while idle
	input wire eeprom_access_pkg::twi_cmd_t cmd, // start, stop, write or read
	input wire logic [7:0] tx_byte, // byte to send
	input wire logic master_nack, // leave acknowledge high after a read
	input wire logic sda_in, // data line level
	output logic busy, // command in progress
	output logic done, // one-cycle end of command
	output logic ack_missing, // no acknowledge after a written byte
	output logic [7:0] rx_byte, // byte received
	output logic scl_oe, // pull clock line low
	output logic sda_oe // pull data line low
);
	eeprom_access_pkg::twi_cmd_t cur, next_cur;
	logic [1:0] phase, next_phase;
	logic [3:0] bit_idx, next_bit_idx;
	logic [7:0] next_rx;
	logic next_busy, next_done, next_ack, next_scl, next_sda, finish;

	always_comb begin
		next_cur = cur;
		next_phase = phase;
		next_bit_idx = bit_idx;
		next_rx = rx_byte;
		next_busy = busy;
		next_ack = ack_missing;
		next_scl = scl_oe;
		next_sda = sda_oe;
		finish = 1'b0;
		if (!busy) begin
			if (cmd_valid) begin
				next_busy = 1'b1;
				next_cur = cmd;
				next_phase = 2'h0;
				next_bit_idx = 4'h0;
				next_rx = tx_byte;
				next_ack = 1'b0;
			end
		end else if (tick) begin
			next_phase = phase + 2'h1;
			case (cur)
				eeprom_access_pkg::CMD_START: begin
					// Works from idle and as a repeated start with the clock low.
					case (phase)
						2'h0: next_sda = 1'b0;
						2'h1: next_scl = 1'b0;
						2'h2: next_sda = 1'b1;
						default: begin
							next_scl = 1'b1;
							finish = 1'b1;
						end
					endcase
				end
				eeprom_access_pkg::CMD_STOP: begin
					case (phase)
						2'h0: next_sda = 1'b1;
						2'h1: next_scl = 1'b0;
						2'h2: next_sda = 1'b0;
						default: finish = 1'b1;
					endcase
				end
				default: begin
					case (phase)
						2'h0: begin
							if (bit_idx == 4'h8) begin
								next_sda = (cur == eeprom_access_pkg::CMD_READ) && !master_nack;
							end else begin
								next_sda = (cur == eeprom_access_pkg::CMD_WRITE) && !rx_byte[7];
							end
						end
						2'h1: next_scl = 1'b0;
						2'h2: begin
							if (bit_idx == 4'h8) begin
								next_ack = (cur == eeprom_access_pkg::CMD_WRITE) && sda_in;
							end else begin
								next_rx = {rx_byte[6:0], sda_in};
							end
						end
						default: begin
							next_scl = 1'b1;
							next_bit_idx = bit_idx + 4'h1;
							finish = (bit_idx == 4'h8);
						end
					endcase
				end
			endcase
			if (finish) begin
				next_busy = 1'b0;
				next_phase = 2'h0;
			end
		end
		next_done = finish;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur <= eeprom_access_pkg::CMD_START;
			phase <= 2'h0;
			bit_idx <= 4'h0;
			rx_byte <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			ack_missing <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			cur <= next_cur;
			phase <= next_phase;
			bit_idx <= next_bit_idx;
			rx_byte <= next_rx;
			busy <= next_busy;
			done <= next_done;
			ack_missing <= next_ack;
			scl_oe <= next_scl;
			sda_oe <= next_sda;
		end
	end
endmodule // twi_byte_engine
`default_nettype wire

/* test/eeprom_access_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_port_assertions #(
	parameter int QUARTER_CYCLES = 2,
	parameter int AUTOLOAD_WORDS = 4
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [11:0] addr, // register address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [31:0] rdata, // read data
	input wire logic irq, // level interrupt
	input wire logic sda_oe, // data line pulled low
	input wire logic cfg_load_valid, // autoloaded word pulse
	input wire logic [6:0] cfg_load_addr, // autoloaded address
	input wire logic [15:0] cfg_load_data // autoloaded word
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic hit_acc;
	assign hit_acc = rd && addr == eeprom_access_pkg::OFF_ACCESS;

	AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_RSVD_BIT: assert property ($past(hit_acc) |-> !rdata[8])
		else $error("reserved bit reads one");
	AST_AL_OK: assert property ($past(hit_acc) && rdata[4] |-> rdata[3])
		else $error("autoload status set without success bit");
	AST_AL_CLR: assert property (hit_acc ##1 (hit_acc && rdata[4]) |=> !rdata[4])
		else $error("autoload status not cleared by read");
	AST_CFG_PULSE: assert property (cfg_load_valid |=> !cfg_load_valid)
		else $error("load pulse longer than one cycle");
	AST_CFG_HOLD: assert property (!cfg_load_valid |-> $stable(cfg_load_data) && $stable(cfg_load_addr))
		else $error("loaded word changed without pulse");
	AST_CFG_RANGE: assert property (cfg_load_valid |-> cfg_load_addr < AUTOLOAD_WORDS)
		else $error("autoload address out of range");
	// The launch must reach the line within a few quarters even at the slowest rate.
	AST_LAUNCH: assert property (wr && addr == eeprom_access_pkg::OFF_ACCESS && wdata[0] && wdata[5] |-> ##[1:1000] sda_oe)
		else $error("start did not begin a cycle");
	AST_IRQ_MASK: assert property (wr && addr == eeprom_access_pkg::OFF_IRQ_MASK && wdata[2:0] == 3'h0 |=> !irq)
		else $error("interrupt high with all masked");

	COV_LAUNCH: cover property (wr && addr == eeprom_access_pkg::OFF_ACCESS && wdata[0]);
	COV_LOAD: cover property (cfg_load_valid);
	COV_AL_CLR: cover property (hit_acc ##1 (hit_acc && rdata[4]));
endmodule // eeprom_access_port_assertions

bind eeprom_access_port eeprom_access_port_assertions #(
	.QUARTER_CYCLES(QUARTER_CYCLES), .AUTOLOAD_WORDS(AUTOLOAD_WORDS)) eeprom_access_port_assertions_inst (
	.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
	.sda_oe(sda_oe), .cfg_load_valid(cfg_load_valid), .cfg_load_addr(cfg_load_addr),
	.cfg_load_data(cfg_load_data));
`default_nettype wire

/* test/serial_eeprom_access_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_access_port_test;
	localparam logic [11:0] ACC = eeprom_access_pkg::OFF_ACCESS;
	localparam logic [11:0] STS = eeprom_access_pkg::OFF_IRQ_STATUS;
	localparam logic [11:0] MSK = eeprom_access_pkg::OFF_IRQ_MASK;
	logic clk, nrst, wr, rd, irq, scl_oe, sda_oe, pull, nack_all, cfg_load_valid;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [6:0] cfg_load_addr;
	logic [15:0] cfg_load_data;
	int n_mismatch, checked;
	wire logic scl_line, sda_line;
	assign scl_line = !scl_oe;
	assign sda_line = !(sda_oe || pull);
	eeprom_access_port #(.QUARTER_CYCLES(2), .AUTOLOAD_WORDS(2)) eeprom_access_port_inst (
		.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq(irq), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
		.cfg_load_valid(cfg_load_valid), .cfg_load_addr(cfg_load_addr),
		.cfg_load_data(cfg_load_data));
	serial_eeprom_model serial_eeprom_model_inst (.scl(scl_line), .sda(sda_line),
		.nack_all(nack_all), .pull(pull));
	always #10 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic wait_idle;
		rd_reg(ACC);
		for (int i = 0; i < 2000 && d[0] !== 1'b0; i++) rd_reg(ACC);
	endtask
	task automatic end_of_test;
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic t_reset;
		rd_reg(ACC);
		check(d, 32'h00000060);
		rd_reg(12'h0c0);
		check(d, 32'h00000000);
		rd_reg(MSK);
		check(d, 32'h00000000);
	endtask
	// The second launch lands while busy and must leave no trace.
	task automatic t_write;
		wr_reg(MSK, 32'h7);
		wr_reg(ACC, 32'hbeef0b63);
		wr_reg(ACC, 32'h12340023);
		wait_idle();
		check(d, 32'hbeef0a62);
		check({16'h0, serial_eeprom_model_inst.mem[5]}, 32'h0000beef);
		check({31'h0, irq}, 32'h1);
		rd_reg(STS);
		check(d, 32'h1);
		wr_reg(STS, 32'h1);
		@(negedge clk);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_read;
		wr_reg(ACC, 32'h00000ae1);
		wait_idle();
		check(d, 32'hbeef0ae0);
		wr_reg(STS, 32'h1);
	endtask
	task automatic t_nack;
		nack_all <= 1'b1;
		wr_reg(ACC, 32'h00001263);
		wait_idle();
		check(d, 32'h00001266);
		rd_reg(STS);
		check(d, 32'h3);
		wr_reg(MSK, 32'h0);
		@(negedge clk);
		check({31'h0, irq}, 32'h0);
		wr_reg(STS, 32'h3);
		wr_reg(MSK, 32'h7);
		nack_all <= 1'b0;
	endtask
	task automatic t_autoload;
		wr_reg(ACC, 32'h00000040);
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 3000 && cfg_load_valid !== 1'b1; i++) @(negedge clk);
			check({cfg_load_addr, 9'h0, cfg_load_data}, {7'(k), 9'h0, 16'h1000 + 16'(k)});
			@(negedge clk);
		end
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ACC;
		@(posedge clk);
		@(negedge clk);
		// The error flag from the refused access stands, since autoload is no software launch.
		check(rdata & 32'hffff, 32'h5c);
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(rdata & 32'hffff, 32'h4c);
		rd_reg(STS);
		check(d, 32'h4);
	endtask

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 12'h000;
		wdata = 32'h0;
		nack_all = 1'b0;
		n_mismatch = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_write();
		t_read();
		t_nack();
		t_autoload();
		end_of_test();
	end
	// Each access takes under a thousand cycles here, so this leaves wide margin.
	initial begin
		#1200000;
		n_mismatch++;
		end_of_test();
	end
endmodule // serial_eeprom_access_port_test
`default_nettype wire

/* test/serial_eeprom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_model (
	input wire logic scl, // clock line level
	input wire logic sda, // data line level
	input wire logic nack_all, // withhold every acknowledge
	output logic pull // pull data line low
);
	logic [15:0] mem [0:127];
	logic [7:0] sh;
	logic [15:0] tx;
	logic [6:0] wa;
	logic [7:0] hb;
	logic rdm, ackph;
	int bc, nb;
	initial begin
		pull = 1'b0;
		bc = 0;
		nb = 0;
		rdm = 1'b0;
		ackph = 1'b0;
		for (int i = 0; i < 128; i++) mem[i] = 16'h1000 + 16'(i);
	end
	always @(negedge sda) if (scl) begin
		bc = 0;
		nb = 0;
		ackph = 1'b0;
		rdm = 1'b0;
	end
	always @(posedge scl) if (!ackph) begin
		sh = {sh[6:0], sda};
		tx = {tx[14:0], 1'b1};
		bc = bc + 1;
	end
	// Changes land only while the clock is low, so no false start or stop is made.
	always @(negedge scl) begin
		if (ackph) begin
			ackph = 1'b0;
			pull = rdm && !tx[15];
		end else if (bc == 8) begin
			bc = 0;
			ackph = 1'b1;
			if (rdm) pull = 1'b0;
			else begin
				if (nb == 0) begin
					rdm = sh[0];
					tx = mem[wa];
				end
				if (nb == 1) wa = sh[6:0];
				if (nb == 2) hb = sh;
				if (nb == 3) mem[wa] = {hb, sh};
				nb = nb + 1;
				pull = !nack_all;
			end
		end else if (rdm) pull = !tx[15];
	end
endmodule // serial_eeprom_model
`default_nettype wire
